/* File: verilog/pmm_params.svh */
/*
 * timing counts and constants of the microphone mode and startup block.
 * assumes a 10 MHz system clock; the link clock is sampled as a plain input.
 */
`ifndef PMM_PARAMS_SVH
`define PMM_PARAMS_SVH

// system clock
`define PMM_CLK_HZ 10000000
// wake flag blanking after power-up, in ms
`define PMM_BLANK_MS 1000
`define PMM_BLANK_CYC ((`PMM_CLK_HZ / 1000) * `PMM_BLANK_MS)
// anti-pop pattern must start within this many ns of clock start
`define PMM_POP_START_NS 50000
`define PMM_POP_START_CYC ((`PMM_POP_START_NS * (`PMM_CLK_HZ / 1000000)) / 1000)
// link clock frequency bounds in kHz
`define PMM_STBY_MAX_KHZ 250
`define PMM_LP_MIN_KHZ 350
`define PMM_LP_MAX_KHZ 900
`define PMM_FP_MIN_KHZ 1100
// a link clock low half-period longer than this means the clock stopped, in ns
`define PMM_STOP_NS 20000
`define PMM_STOP_CYC ((`PMM_STOP_NS * (`PMM_CLK_HZ / 1000000)) / 1000)
// period thresholds in system cycles (period = clk_hz / f)
`define PMM_PER_STBY (`PMM_CLK_HZ / (`PMM_STBY_MAX_KHZ * 1000))
`define PMM_PER_LP_SLOW (`PMM_CLK_HZ / (`PMM_LP_MIN_KHZ * 1000))
`define PMM_PER_LP_FAST (`PMM_CLK_HZ / (`PMM_LP_MAX_KHZ * 1000))
`define PMM_PER_FP (`PMM_CLK_HZ / (`PMM_FP_MIN_KHZ * 1000))
// number of alternating pattern bits before audio takes over
`define PMM_POP_BITS 16

`endif

/* File: verilog/pmm_pkg.sv */
/*
 * types of the microphone mode and startup block.
 * assumes nothing of its surroundings.
 */
package pmm_pkg;
    // ========================================
    // operating modes
    typedef enum logic [1:0] {
        PMM_LISTEN = 2'b00,
        PMM_STANDBY = 2'b01,
        PMM_LOW_POWER = 2'b10,
        PMM_FULL_POWER = 2'b11
    } pmm_mode_e;
endpackage

/* File: verilog/pmm_buf_if.sv */
/*
 * valid/ready carrier for audio bits between the block and its buffer.
 * assumes one clock for both ends.
 */
interface pmm_buf_if;
    logic valid;
    logic ready;
    logic data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: verilog/pmm_buf2.sv */
/*
 * two-entry buffer of audio bits with valid and ready on both sides.
 * assumes source and sink share the system clock.
 */
module pmm_buf2 #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // filling side
    pmm_buf_if.snk in_if,
    // draining side
    output logic out_valid_o,
    output logic out_data_o,
    input wire logic out_ready_i
);
    // refuse shapes that the one-bit pointers cannot serve
    if (WIDTH != 1 || DEPTH != 2) begin
        $error("pmm_buf2 serves one-bit, two-entry storage only");
    end

    typedef struct packed {
        logic [DEPTH-1:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } pmm_buf_s;

    pmm_buf_s st;
    pmm_buf_s next_st;
    logic push;
    logic pop;

    // ========================================
    // handshakes
    assign push = in_if.valid && (st.cnt != 2'h2);
    assign pop = out_ready_i && (st.cnt != 2'h0);
    assign in_if.ready = (st.cnt != 2'h2);
    assign out_valid_o = (st.cnt != 2'h0);
    assign out_data_o = st.mem[st.rd];

    // next state
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_if.data;
            next_st.wr = ~st.wr;
        end
        if (pop) begin
            next_st.rd = ~st.rd;
        end
        next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    end

    // state register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

/* File: verilog/pmm_core.sv */
/*
 * mode entry, power-up blanking, anti-pop startup and left/right slot
 * driving of a pulse-density microphone.
 * assumes power-up reset on rst_i, a 10 MHz clock_i, and a link clock,
 * channel select, comparator output and modulator bit that all come from
 * outside the clock domain and are synchronised here.
 */
`include "pmm_params.svh"

module pmm_core #(
    parameter int BLANK_CYC = `PMM_BLANK_CYC,
    parameter int POP_BITS = `PMM_POP_BITS
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // link from host
    input wire logic link_clk_i,
    input wire logic chan_sel_i,
    // analog front end
    input wire logic thresh_hit_i,
    input wire logic mod_bit_i,
    // data pin
    output logic data_o,
    output logic data_oe_o,
    // wake flag and mode
    output logic sound_wake_trigger_o,
    output pmm_pkg::pmm_mode_e mode_o
);
    // refuse counts that the blanking and pattern counters cannot hold
    if (BLANK_CYC < 1 || POP_BITS < 2 || POP_BITS > 255) begin
        $error("pmm_core: unusable blank or pattern count");
    end

    typedef struct packed {
        logic [2:0] lck_s;
        logic [1:0] sel_s;
        logic [1:0] hit_s;
        logic [1:0] mod_s;
        logic [31:0] blank_cnt;
        logic blanked;
        logic [15:0] half_cnt;
        logic [15:0] per_cnt;
        logic [15:0] period;
        logic running;
        logic [7:0] pop_cnt;
        logic pop_phase;
        logic audio_seen;
        logic drive_bit;
        logic data;
        logic data_oe;
        logic wake;
        pmm_pkg::pmm_mode_e mode;
    } pmm_core_s;

    pmm_core_s st;
    pmm_core_s next_st;
    logic rise;
    logic fall;
    logic launch;
    logic release_slot;
    logic clocked_audio;
    pmm_buf_if bif ();
    logic buf_valid;
    logic buf_data;

    // ========================================
    // classify a measured link clock period into a mode
    function automatic pmm_pkg::pmm_mode_e classify(input logic [15:0] per);
        if (per <= 16'(`PMM_PER_FP)) begin
            classify = pmm_pkg::PMM_FULL_POWER;
        end else if (per >= 16'(`PMM_PER_LP_FAST) && per <= 16'(`PMM_PER_LP_SLOW)) begin
            classify = pmm_pkg::PMM_LOW_POWER;
        end else begin
            classify = pmm_pkg::PMM_STANDBY;
        end
    endfunction

    // ========================================
    // edges of the synchronised link clock, seen past the second stage
    assign rise = st.lck_s[1] && !st.lck_s[2];
    assign fall = !st.lck_s[1] && st.lck_s[2];
    // left launches on falling, right on rising; the opposite edge releases
    assign launch = st.sel_s[1] ? rise : fall;
    assign release_slot = st.sel_s[1] ? fall : rise;
    assign clocked_audio = (st.mode == pmm_pkg::PMM_LOW_POWER)
        || (st.mode == pmm_pkg::PMM_FULL_POWER);

    // modulator bits enter the buffer once per link period in audio modes
    assign bif.valid = clocked_audio && rise;
    assign bif.data = st.mod_s[1];

    pmm_buf2 #(
        .WIDTH(1),
        .DEPTH(2)
    ) u_buf (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_if(bif.snk),
        .out_valid_o(buf_valid),
        .out_data_o(buf_data),
        // drained at every launch in audio modes, so pattern slots discard stale bits
        .out_ready_i(clocked_audio && launch)
    );

    // ========================================
    // next state
    always_comb begin
        next_st = st;
        next_st.lck_s = {st.lck_s[1:0], link_clk_i};
        next_st.sel_s = {st.sel_s[0], chan_sel_i};
        next_st.hit_s = {st.hit_s[0], thresh_hit_i};
        next_st.mod_s = {st.mod_s[0], mod_bit_i};

        // one second blanking of the wake flag after power-up
        if (st.blanked) begin
            next_st.blank_cnt = st.blank_cnt + 32'h1;
            if (st.blank_cnt == 32'(BLANK_CYC - 1)) begin
                next_st.blanked = 1'b0;
            end
        end
        // comparator drives the flag in every mode; low while blanked
        next_st.wake = st.blanked ? 1'b0 : st.hit_s[1];

        // period measurement and stop detection
        next_st.per_cnt = (st.per_cnt == 16'hffff) ? st.per_cnt : st.per_cnt + 16'h1;
        next_st.half_cnt = (st.half_cnt == 16'hffff) ? st.half_cnt : st.half_cnt + 16'h1;
        if (rise || fall) begin
            next_st.half_cnt = 16'h0;
        end
        if (rise) begin
            next_st.per_cnt = 16'h0;
            next_st.period = st.per_cnt + 16'h1;
            if (st.running) begin
                next_st.mode = classify(st.per_cnt + 16'h1);
            end
            next_st.running = 1'b1;
        end
        // clock held low: back to listening, next start replays the pattern
        if (st.half_cnt >= 16'(`PMM_STOP_CYC) && !st.lck_s[1]) begin
            next_st.running = 1'b0;
            next_st.mode = pmm_pkg::PMM_LISTEN;
            next_st.pop_cnt = 8'h0;
            next_st.pop_phase = 1'b0; // next pattern starts low again
            next_st.audio_seen = 1'b0;
        end

        // data slot: anti-pop pattern first, then buffered audio bits
        if (clocked_audio && launch) begin
            next_st.data_oe = 1'b1;
            if (st.pop_cnt != 8'(POP_BITS)) begin
                next_st.pop_phase = ~st.pop_phase;
                next_st.data = st.pop_phase;
                next_st.pop_cnt = st.pop_cnt + 8'h1;
            end else if (buf_valid) begin
                next_st.data = buf_data;
                next_st.audio_seen = 1'b1;
            end else begin
                next_st.data = st.pop_phase; // keep toggling, no gap on the line
                next_st.pop_phase = ~st.pop_phase;
            end
        end else if (release_slot || !clocked_audio) begin
            next_st.data_oe = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.blanked <= 1'b1;
            st.half_cnt <= 16'hffff;
            st.mode <= pmm_pkg::PMM_LISTEN;
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // outputs straight from the state register
    assign data_o = st.data;
    assign data_oe_o = st.data_oe;
    assign sound_wake_trigger_o = st.wake;
    assign mode_o = st.mode;
endmodule

/* File: testbench/pmm_host.sv */
/*
 * host model that supplies the microphone link clock.
 * assumes the bench sets the half period in ns while run_i is low.
 */
module pmm_host (
    // control from bench
    input wire logic run_i,
    input wire logic [15:0] half_ns_i,
    // link clock to block
    output logic link_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // clock runs only on request and stands low between bursts
    always begin
        link_clk_o = 1'b0;
        wait (run_i);
        #23;
        while (run_i) begin
            #(half_ns_i) link_clk_o = 1'b1;
            #(half_ns_i) link_clk_o = 1'b0;
        end
    end
endmodule

/* File: testbench/pmm_core_assertions.sv */
/*
 * concurrent checks on the ports of the microphone mode block.
 * assumes binding into pmm_core with its blanking count handed on.
 */
module pmm_core_chk #(
    parameter int BLANK_CYC = 100
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // watched inputs and outputs
    input wire logic link_clk_i,
    input wire logic chan_sel_i,
    input wire logic thresh_hit_i,
    input wire logic data_o,
    input wire logic data_oe_o,
    input wire logic sound_wake_trigger_o,
    input wire pmm_pkg::pmm_mode_e mode_o
);
    logic lk;
    logic [5:0] go_h;
    logic [5:0] end_h;
    int cnt;
    int lowc;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // ========================================
    // launch and release edge history, time since reset, link low time
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            lk <= 1'b0;
            go_h <= '0;
            end_h <= '0;
            cnt <= 0;
            lowc <= 0;
        end else begin
            lk <= link_clk_i;
            go_h <= {go_h[4:0], link_clk_i != lk && link_clk_i == chan_sel_i};
            end_h <= {end_h[4:0], link_clk_i != lk && link_clk_i != chan_sel_i};
            cnt <= cnt + 1;
            lowc <= link_clk_i ? 0 : lowc + 1;
        end
    end
    // ========================================
    // properties
    a_idle_no_drive:
    assert property (!mode_o[1] && !$past(mode_o[1]) |-> !data_oe_o)
        else $error("data pin driven outside audio modes");
    a_wake_blank:
    assert property (cnt + 1 < BLANK_CYC |-> !sound_wake_trigger_o)
        else $error("wake flag active while blanked");
    a_wake_follow:
    assert property (cnt > BLANK_CYC + 8 ##0 $stable(thresh_hit_i) [*6]
        |-> sound_wake_trigger_o == thresh_hit_i)
        else $error("wake flag does not follow comparator");
    a_oe_launch:
    assert property ($rose(data_oe_o) |-> |go_h)
        else $error("drive began without a launch edge");
    a_oe_release:
    assert property ($fell(data_oe_o) |-> |end_h || mode_o == pmm_pkg::PMM_LISTEN)
        else $error("drive ended without a release edge");
    a_data_steady:
    assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
        else $error("data changed inside a slot");
    a_stop_listen:
    assert property (lowc > 220 |-> mode_o == pmm_pkg::PMM_LISTEN)
        else $error("no listening mode after clock stop");
    a_no_clk_hold:
    assert property (lowc > 6 && $past(mode_o) == pmm_pkg::PMM_LISTEN
        |-> mode_o == pmm_pkg::PMM_LISTEN)
        else $error("mode left listening without a clock");
endmodule
bind pmm_core pmm_core_chk #(.BLANK_CYC(BLANK_CYC)) chk_u (
    .clock_i, .rst_i, .link_clk_i, .chan_sel_i, .thresh_hit_i, .data_o,
    .data_oe_o, .sound_wake_trigger_o, .mode_o
);

/* File: testbench/tb_pmm_core.sv */
/*
 * self-checking bench of the microphone mode block.
 * assumes the host model and the bound checker are compiled alongside.
 */
module tb_pmm_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic link_clk;
    logic chan_sel = 1'b0;
    logic thresh = 1'b0;
    logic mod_bit = 1'b1;
    logic run = 1'b0;
    logic [15:0] half = 16'h0190;
    logic data;
    logic oe;
    logic wake;
    pmm_pkg::pmm_mode_e mode;
    int fail_count = 0;
    int comparisons = 0;
    // ========================================
    // block, host and clock
    pmm_core #(.BLANK_CYC(100)) dut_u (
        .clock_i, .rst_i, .link_clk_i(link_clk), .chan_sel_i(chan_sel),
        .thresh_hit_i(thresh), .mod_bit_i(mod_bit), .data_o(data),
        .data_oe_o(oe), .sound_wake_trigger_o(wake), .mode_o(mode)
    );
    pmm_host host_u (.run_i(run), .half_ns_i(half), .link_clk_o(link_clk));
    always #50 clock_i = ~clock_i;
    // ========================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic smp(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic cmp(input string what, input logic [1:0] exp, input logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic slot(output logic b);
        int n;
        n = 0;
        while (oe !== 1'b1 && n < 100) begin
            smp(1);
            n++;
        end
        b = (n < 100) ? data : 1'bx;
        while (oe === 1'b1 && n < 200) begin
            smp(1);
            n++;
        end
    endtask
    // sixteen alternating slots then the modulator bit that the caller holds
    task automatic chk_stream(input logic aud);
        logic b;
        time t0;
        t0 = $time;
        for (int i = 0; i < 20; i++) begin
            slot(b);
            if (i == 0) begin
                cmp("first slot time", 2'h1, $time - t0 < 50000);
            end
            cmp("slot bit", i < 16 ? i[0] : aud, b);
        end
    endtask
    task automatic stop_clk();
        tick(1);
        run <= 1'b0;
        smp(300);
        cmp("mode after stop", pmm_pkg::PMM_LISTEN, mode);
        cmp("oe after stop", 2'h0, oe);
    endtask
    // ========================================
    // scenarios
    task automatic t_powerup();
        tick(1);
        thresh <= 1'b1;
        smp(50);
        cmp("mode at power-up", pmm_pkg::PMM_LISTEN, mode);
        cmp("wake blanked", 2'h0, wake);
        smp(70);
        cmp("wake set", 2'h1, wake);
        tick(1);
        thresh <= 1'b0;
        smp(8);
        cmp("wake clear", 2'h0, wake);
    endtask
    task automatic t_left_full();
        tick(1);
        chan_sel <= 1'b0;
        half <= 16'h0190;
        run <= 1'b1; // wake stays low meanwhile
        chk_stream(1'b1);
        cmp("mode fast clock", pmm_pkg::PMM_FULL_POWER, mode);
        cmp("wake low at mode entry", 2'h0, wake);
        tick(1);
        thresh <= 1'b1;
        smp(8);
        cmp("wake in audio mode", 2'h1, wake);
        tick(1);
        thresh <= 1'b0;
        stop_clk();
    endtask
    task automatic t_right_low();
        tick(1);
        chan_sel <= 1'b1;
        half <= 16'h03e8;
        mod_bit <= 1'b0;
        run <= 1'b1;
        chk_stream(1'b0);
        cmp("mode mid clock", pmm_pkg::PMM_LOW_POWER, mode);
        stop_clk();
    endtask
    task automatic t_standby();
        tick(1);
        chan_sel <= 1'b0;
        half <= 16'h0bb8;
        run <= 1'b1;
        smp(400);
        cmp("mode slow clock", pmm_pkg::PMM_STANDBY, mode);
        cmp("no drive in standby", 2'h0, oe);
        stop_clk();
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ========================================
    // main sequence and watchdog
    initial begin
        tick(3);
        rst_i <= 1'b0;
        t_powerup();
        t_left_full();
        t_right_low();
        t_standby();
        wrap_up();
    end
    initial begin
        #1000000;
        fail_count++;
        wrap_up();
    end
endmodule
